// [verilog/unary_ops_pkg.sv]
// Purpose: shared constants and types for the file-register unary op unit
// Assumes: 8-bit data, 7-bit file address, 13-bit program counter
// Notes: opcode codes are local to this unit
package unary_ops_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	localparam int LIT_W = 11;
	localparam int LATCH_LO = 3;
	localparam int LATCH_HI = 4;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic ZF_RESET = 1'b0;
	localparam logic [1:0] TWO_CYCLE_EXTRA = 2'h1;

	typedef enum logic [2:0] {
		complement_file_op = 3'h0,
		clear_file_op = 3'h1,
		decrement_file_op = 3'h2,
		clear_working_op = 3'h3,
		decrement_skip_zero_op = 3'h4,
		increment_skip_zero_op = 3'h5,
		absolute_branch_op = 3'h6,
		no_op = 3'h7
	} op_e;

	typedef enum logic [0:0] {
		st_exec = 1'h0,
		st_flush = 1'h1
	} seq_e;
endpackage : unary_ops_pkg

// [verilog/unary_alu.sv]
// Purpose: combinational result and zero detect for the unary ops
// Assumes: operand is the addressed file register value
// Notes: result is meaningless for branch and no-op
`timescale 1ns/1ps
module unary_alu
	import unary_ops_pkg::*;
(
	// operation
	input wire op_e op_in,
	input wire logic [DATA_W-1:0] operand_in,
	// result
	output logic [DATA_W-1:0] result_out,
	output logic zero_out
);
	always_comb
	begin
		case (op_in)
			complement_file_op: result_out = ~operand_in;
			clear_file_op: result_out = ZERO_BYTE;
			clear_working_op: result_out = ZERO_BYTE;
			decrement_file_op: result_out = operand_in - 8'h01;
			decrement_skip_zero_op: result_out = operand_in - 8'h01;
			increment_skip_zero_op: result_out = operand_in + 8'h01;
			default: result_out = operand_in;
		endcase
		zero_out = (result_out == ZERO_BYTE);
	end
endmodule : unary_alu

// [verilog/file_register_unary_ops.sv]
// Purpose: executes unary file/working register ops and absolute branch
// Assumes: decode supplies op, address, dest bit, literal and file data
// Notes: exec_valid_in is ignored while a flush cycle runs (busy_out high)
`timescale 1ns/1ps
module file_register_unary_ops
	import unary_ops_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// decoded instruction
	input wire logic exec_valid_in,
	input wire op_e op_in,
	input wire logic [ADDR_W-1:0] file_addr_in,
	input wire logic dest_file_in,
	input wire logic [LIT_W-1:0] literal_in,
	input wire logic [DATA_W-1:0] file_data_in,
	input wire logic [DATA_W-1:0] pc_latch_in,
	input wire logic [PC_W-1:0] pc_next_in,
	// file register write port
	output logic file_we_out,
	output logic [ADDR_W-1:0] file_waddr_out,
	output logic [DATA_W-1:0] file_wdata_out,
	// core state
	output logic [DATA_W-1:0] w_out,
	output logic zero_flag_out,
	output logic [PC_W-1:0] pc_out,
	output logic pc_load_out,
	output logic busy_out,
	output logic flush_out
);
	logic [DATA_W-1:0] alu_res;
	logic alu_zero;
	logic [DATA_W-1:0] w_ff;
	logic zf_ff;
	logic [PC_W-1:0] pc_ff;
	logic pc_load_ff;
	logic file_we_ff;
	logic [ADDR_W-1:0] file_waddr_ff;
	logic [DATA_W-1:0] file_wdata_ff;
	seq_e seq_ff;
	seq_e nxt_seq;
	logic go;
	logic skip_hit;
	logic to_file;
	logic to_w;
	logic take_branch;

	unary_alu u_alu (
		.op_in(op_in),
		.operand_in(file_data_in),
		.result_out(alu_res),
		.zero_out(alu_zero)
	);

	assign go = exec_valid_in && (seq_ff == st_exec);
	assign take_branch = go && (op_in == absolute_branch_op);
	assign skip_hit = go && alu_zero &&
		(op_in == decrement_skip_zero_op || op_in == increment_skip_zero_op);

	always_comb
	begin
		to_file = 1'b0;
		to_w = 1'b0;
		case (op_in)
			clear_file_op: to_file = 1'b1;
			clear_working_op: to_w = 1'b1;
			complement_file_op, decrement_file_op,
			decrement_skip_zero_op, increment_skip_zero_op:
			begin
				to_file = dest_file_in;
				to_w = !dest_file_in;
			end
			default:
			begin
				to_file = 1'b0;
				to_w = 1'b0;
			end
		endcase
	end

	// sequencer: second cycle for skip or branch
	always_comb
	begin
		nxt_seq = st_exec;
		case (seq_ff)
			st_exec:
				if (skip_hit || take_branch)
					nxt_seq = st_flush;
			st_flush: nxt_seq = st_exec;
			default: nxt_seq = st_exec;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			seq_ff <= st_exec;
		else
			seq_ff <= nxt_seq;
	end

	// working register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			w_ff <= W_RESET;
		else if (go && to_w)
			w_ff <= alu_res;
	end

	// zero flag
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			zf_ff <= ZF_RESET;
		else if (go)
		begin
			case (op_in)
				clear_file_op, clear_working_op: zf_ff <= 1'b1;
				complement_file_op, decrement_file_op: zf_ff <= alu_zero;
				default: zf_ff <= zf_ff;
			endcase
		end
	end

	// file write port
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			file_we_ff <= 1'b0;
			file_waddr_ff <= '0;
			file_wdata_ff <= ZERO_BYTE;
		end
		else
		begin
			file_we_ff <= go && to_file;
			file_waddr_ff <= file_addr_in;
			file_wdata_ff <= alu_res;
		end
	end

	// program counter load
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			pc_ff <= PC_RESET;
			pc_load_ff <= 1'b0;
		end
		else
		begin
			pc_load_ff <= take_branch;
			if (take_branch)
				pc_ff <= {pc_latch_in[LATCH_HI:LATCH_LO], literal_in};
			else
				pc_ff <= pc_next_in;
		end
	end

	assign w_out = w_ff;
	assign zero_flag_out = zf_ff;
	assign pc_out = pc_ff;
	assign pc_load_out = pc_load_ff;
	assign file_we_out = file_we_ff;
	assign file_waddr_out = file_waddr_ff;
	assign file_wdata_out = file_wdata_ff;
	assign busy_out = (seq_ff == st_flush);
	assign flush_out = (seq_ff == st_flush);

	a_clear_file_op_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == clear_file_op |=> zf_ff && file_we_ff && file_wdata_ff == 8'h00)
		else $error("clear file did not zero and flag");
	a_clear_working_op_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == clear_working_op |=> zf_ff && w_ff == 8'h00 && !file_we_ff)
		else $error("clear W failed");
	a_complement_file_op_dest: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == complement_file_op && dest_file_in |=> file_we_ff && file_wdata_ff == ~$past(file_data_in))
		else $error("complement to file wrong");
	a_decrement_file_op_w: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == decrement_file_op && !dest_file_in |=> !file_we_ff && w_ff == $past(file_data_in) - 8'h01)
		else $error("decrement to W wrong");
	a_dec_skip: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == decrement_skip_zero_op && file_data_in == 8'h01 |=> flush_out ##1 !flush_out)
		else $error("decrement skip missing");
	a_inc_skip: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == increment_skip_zero_op |=> flush_out == ($past(file_data_in) == 8'hFF) && $stable(zf_ff))
		else $error("increment skip wrong");
	a_branch_pc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == absolute_branch_op |=> pc_load_ff && pc_ff == {$past(pc_latch_in[4:3]), $past(literal_in)})
		else $error("branch target wrong");
	a_branch_two: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == absolute_branch_op |=> flush_out && $stable(zf_ff))
		else $error("branch not two cycles");
	a_zero_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && (op_in == complement_file_op || op_in == decrement_file_op) |=>
		zf_ff == ($past(op_in) == complement_file_op ? $past(file_data_in) == 8'hFF : $past(file_data_in) == 8'h01))
		else $error("zero flag mismatch");
	a_complement_file_op_w: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == complement_file_op && !dest_file_in |=> !file_we_ff && w_ff == ~$past(file_data_in))
		else $error("complement to W wrong");
	a_dec_skip_flags: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		go && op_in == decrement_skip_zero_op |=> $stable(zf_ff) && flush_out == ($past(file_data_in) == 8'h01))
		else $error("decrement skip flags or skip wrong");
	a_busy_refuse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		busy_out |=> !file_we_ff && !pc_load_ff && !busy_out && $stable(w_ff) && $stable(zf_ff))
		else $error("request taken during flush");

	c_skip: cover property (@(posedge sys_clk_in) disable iff (rst_in) skip_hit);
	c_branch: cover property (@(posedge sys_clk_in) disable iff (rst_in) take_branch);
	c_complement_file_op_w: cover property (@(posedge sys_clk_in) disable iff (rst_in) go && op_in == complement_file_op && !dest_file_in);
	c_refused: cover property (@(posedge sys_clk_in) disable iff (rst_in) busy_out && exec_valid_in);
endmodule : file_register_unary_ops

// [testbench/file_register_unary_ops_tb_top.sv]
// Purpose: random and corner checks of the unary op unit
// Assumes: one op in flight, one flush cycle after a skip hit or branch
// Notes: expected W and zero flag are kept in w_m and z_m
`timescale 1ns/1ps
module file_register_unary_ops_tb_top
	import unary_ops_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic exec_valid_in = 1'b0;
	op_e op_in = no_op;
	logic [6:0] file_addr_in = 7'h00;
	logic dest_file_in = 1'b0;
	logic [10:0] literal_in = 11'h000;
	logic [7:0] file_data_in = 8'h00;
	logic [7:0] pc_latch_in = 8'h00;
	logic [12:0] pc_next_in = 13'h0000;
	logic file_we_out;
	logic [6:0] file_waddr_out;
	logic [7:0] file_wdata_out;
	logic [7:0] w_out;
	logic zero_flag_out;
	logic [12:0] pc_out;
	logic pc_load_out;
	logic busy_out;
	logic flush_out;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	integer seed = 32'hd118fc7f;
	logic [7:0] w_m = 8'h00;
	logic z_m = 1'b0;
	op_e cor_op [8] = '{decrement_skip_zero_op, increment_skip_zero_op, complement_file_op, decrement_file_op,
		clear_file_op, clear_working_op, absolute_branch_op, decrement_skip_zero_op};
	logic [7:0] cor_d [8] = '{8'h01, 8'hFF, 8'hFF, 8'h01, 8'h5A, 8'h33, 8'h00, 8'h00};

	file_register_unary_ops dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .exec_valid_in(exec_valid_in),
		.op_in(op_in), .file_addr_in(file_addr_in), .dest_file_in(dest_file_in), .literal_in(literal_in),
		.file_data_in(file_data_in), .pc_latch_in(pc_latch_in), .pc_next_in(pc_next_in),
		.file_we_out(file_we_out), .file_waddr_out(file_waddr_out), .file_wdata_out(file_wdata_out),
		.w_out(w_out), .zero_flag_out(zero_flag_out), .pc_out(pc_out), .pc_load_out(pc_load_out),
		.busy_out(busy_out), .flush_out(flush_out));

	always #4 sys_clk_in = ~sys_clk_in;

	task give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
		compares++;
		if (exp !== seen)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function logic [7:0] calc(input op_e op, input logic [7:0] d);
		case (op)
			complement_file_op: return ~d;
			decrement_file_op, decrement_skip_zero_op: return d - 8'h01;
			increment_skip_zero_op: return d + 8'h01;
			default: return 8'h00;
		endcase
	endfunction : calc

	task run_op(input op_e op, input logic [7:0] d, input logic dst, input logic [10:0] lit, input logic [7:0] lat);
		logic [7:0] r;
		logic wr;
		logic we;
		logic skip;
		logic [6:0] a;
		logic [12:0] pn;
		r = calc(op, d);
		pn = 13'($random(seed));
		a = 7'($random(seed));
		wr = op inside {complement_file_op, decrement_file_op, decrement_skip_zero_op, increment_skip_zero_op};
		we = (op == clear_file_op) || (wr && dst);
		if (wr && !dst)
			w_m = r;
		if (op == clear_working_op)
			w_m = 8'h00;
		if (op inside {complement_file_op, decrement_file_op})
			z_m = (r == 8'h00);
		if (op inside {clear_file_op, clear_working_op})
			z_m = 1'b1;
		skip = (op == absolute_branch_op) || ((op inside {decrement_skip_zero_op, increment_skip_zero_op}) && r == 8'h00);
		exec_valid_in = 1'b1;
		op_in = op;
		file_data_in = d;
		dest_file_in = dst;
		literal_in = lit;
		pc_latch_in = lat;
		file_addr_in = a;
		pc_next_in = pn;
		@(posedge sys_clk_in);
		#1;
		// a clear-W request during the flush cycle must be ignored
		exec_valid_in = skip;
		op_in = clear_working_op;
		chk("file_we", we, file_we_out);
		if (we)
		begin
			chk("waddr", a, file_waddr_out);
			chk("wdata", r, file_wdata_out);
		end
		chk("w", w_m, w_out);
		chk("zero", z_m, zero_flag_out);
		chk("flush", skip, flush_out);
		chk("busy", skip, busy_out);
		chk("pc_load", op == absolute_branch_op, pc_load_out);
		if (op == absolute_branch_op)
			chk("pc", {lat[4:3], lit}, pc_out);
		else
			chk("pc_seq", pn, pc_out);
		@(posedge sys_clk_in);
		#1;
		if (skip)
		begin
			chk("w_held", w_m, w_out);
			chk("zero_held", z_m, zero_flag_out);
			chk("flush_end", 1'b0, flush_out);
			chk("we_held", 1'b0, file_we_out);
		end
	endtask : run_op

	initial
	begin
		repeat (3) @(posedge sys_clk_in);
		#1;
		chk("w_rst", W_RESET, w_out);
		chk("zero_rst", ZF_RESET, zero_flag_out);
		chk("pc_rst", PC_RESET, pc_out);
		chk("busy_rst", 1'b0, busy_out);
		chk("we_rst", 1'b0, file_we_out);
		chk("pc_load_rst", 1'b0, pc_load_out);
		rst_in = 1'b0;
		for (int i = 0; i < 8; i++)
			run_op(cor_op[i], cor_d[i], ~i[0], 11'h7FF, 8'h18);
		$display("test corners done");
		// mid-run reset with a clear-W request pending: reset must win
		rst_in = 1'b1;
		exec_valid_in = 1'b1;
		op_in = clear_working_op;
		repeat (2) @(posedge sys_clk_in);
		#1;
		chk("w_rst2", W_RESET, w_out);
		chk("zero_rst2", ZF_RESET, zero_flag_out);
		chk("pc_rst2", PC_RESET, pc_out);
		chk("busy_rst2", 1'b0, busy_out);
		chk("we_rst2", 1'b0, file_we_out);
		chk("pc_load_rst2", 1'b0, pc_load_out);
		rst_in = 1'b0;
		exec_valid_in = 1'b0;
		w_m = W_RESET;
		z_m = ZF_RESET;
		$display("test reset done");
		for (int i = 0; i < 400; i++)
			run_op(op_e'(3'($random(seed))), 8'($random(seed)), 1'($random(seed)), 11'($random(seed)), 8'($random(seed)));
		$display("test random done");
		give_verdict();
	end
endmodule : file_register_unary_ops_tb_top
